// [rtl/ssoc_map.svh]
// Constants for the safe-state output control block
`ifndef SSOC_MAP_SVH
`define SSOC_MAP_SVH
`define SSOC_CMD_RELEASE 8'hA5
`define SSOC_CMD_FORCE 8'h4B
`define SSOC_LBIST_PASS 2'h3
`define SSOC_FAULT_COUNT_ZERO 4'h0
`define SSOC_RATIO_OFF 3'h0
`define SSOC_CLK_HZ 10000000
`define SSOC_T1_MS 1
`define SSOC_T2_MS 8
`define SSOC_T3_MS 16
`define SSOC_T4_MS 32
`define SSOC_DEGLITCH_US 10
`define SSOC_TSEL_1MS 2'h0
`define SSOC_TSEL_8MS 2'h1
`define SSOC_TSEL_16MS 2'h2
`define SSOC_TSEL_RESET 2'h1
`define SSOC_RESET_EN_RESET 1'b0
// Live fault vector fields
`define SSOC_LF_SUPPLY_OV 0
`define SSOC_LF_HARD_PD 1
`define SSOC_LF_DCRC 2
`define SSOC_LF_VIN_OV 3
`define SSOC_LF_EXT_RESET 4
`define SSOC_LF_REG_FAULT 5
`define SSOC_LF_FCU_FAIL 6
`define SSOC_LF_W 7
// Sticky flag vector fields
`define SSOC_FL_DCRC 0
`define SSOC_FL_DFS 1
`define SSOC_FL_VIN_OV 2
`define SSOC_FL_XFAIL 3
`define SSOC_FL_WD 4
`define SSOC_FL_XRESET 5
`define SSOC_FL_SFAULT 6
`define SSOC_FL_HFAULT 7
`define SSOC_FL_BANDGAP 8
`define SSOC_FL_CLOCK 9
`define SSOC_FL_HANDSHAKE 10
`define SSOC_FL_W 11
`endif

// [rtl/ssoc_pkg.sv]
// Types and time conversion for the safe-state output control block
package ssoc_pkg;
	typedef enum logic [2:0] {
		PWR_OFF, PWR_POWERUP, PWR_RUN, PWR_MON_STBY, PWR_LP_STBY, PWR_DFS
	} ssoc_pwr_e;
	typedef enum logic {SS_HELD, SS_RELEASED} ssoc_safe_e;
	// Longest time: rounds down
	function automatic int unsigned ms_to_cyc(int unsigned ms,
		int unsigned hz);
		return ms * (hz / 1000);
	endfunction
	// Least time: rounds up
	function automatic int unsigned us_to_cyc(int unsigned us,
		int unsigned hz);
		return (us * (hz / 1000) + 999) / 1000;
	endfunction
endpackage

// [rtl/ssoc_ext_error_monitor_if.sv]
// Signals between the safe-state control and the external error monitor
`timescale 1ns/100ps
interface ssoc_ext_error_monitor_if;
	logic mon_en;
	logic polarity;
	logic [1:0] timer_sel;
	logic flag_clr;
	logic flag;
	logic fault_level;
	logic pin_sense;
	logic confirmed;
	modport ctrl (output mon_en, output polarity, output timer_sel,
		output flag_clr, input flag, input fault_level, input pin_sense,
		input confirmed);
	modport mon (input mon_en, input polarity, input timer_sel,
		input flag_clr, output flag, output fault_level, output pin_sense,
		output confirmed);
endinterface

// [rtl/ssoc_ext_error_monitor.sv]
// External error monitor: deglitch, edge detect, flag and fault timer
`timescale 1ns/100ps
`include "ssoc_map.svh"
module ssoc_ext_error_monitor #(
	parameter int unsigned CNT_W = 20,
	parameter int unsigned T1_CYC = 10000,
	parameter int unsigned T2_CYC = 80000,
	parameter int unsigned T3_CYC = 160000,
	parameter int unsigned T4_CYC = 320000,
	parameter int unsigned DG_CYC = 100
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ext_pin,
	ssoc_ext_error_monitor_if.mon em
);
	localparam logic [7:0] DG_LAST = 8'(DG_CYC - 1);
	logic s1_reg, s2_reg, filt_reg, flag_reg, done_reg, conf_reg;
	logic [7:0] dg_reg;
	logic [CNT_W-1:0] tmr_reg;
	logic [CNT_W-1:0] limit;
	logic changing, dg_done, fault_lvl, new_fault, clr_ok, expire;

	// Filter and edge detection
	assign changing = s2_reg != filt_reg;
	assign dg_done = changing && (dg_reg == DG_LAST);
	assign fault_lvl = filt_reg ^ em.polarity;
	assign new_fault = dg_done && (s2_reg ^ em.polarity) && em.mon_en;
	// A stuck fault level keeps the flag from clearing
	assign clr_ok = em.flag_clr && !fault_lvl;
	assign limit = (em.timer_sel == `SSOC_TSEL_1MS) ? CNT_W'(T1_CYC - 1) :
		(em.timer_sel == `SSOC_TSEL_8MS) ? CNT_W'(T2_CYC - 1) :
		(em.timer_sel == `SSOC_TSEL_16MS) ? CNT_W'(T3_CYC - 1) :
		CNT_W'(T4_CYC - 1);
	assign expire = flag_reg && !done_reg && em.mon_en && (tmr_reg == limit);

	// Pin synchroniser and deglitch filter
	always_ff @(posedge clk) begin
		s1_reg <= ext_pin;
		s2_reg <= s1_reg;
		if (srst || !changing || dg_done) dg_reg <= 8'h00;
		else dg_reg <= dg_reg + 8'h01;
		if (srst) filt_reg <= 1'b0;
		else if (dg_done) filt_reg <= s2_reg;
	end

	// Flag (set wins over clear) and fault timer
	always_ff @(posedge clk) begin
		if (srst) begin
			flag_reg <= 1'b0;
			done_reg <= 1'b0;
			conf_reg <= 1'b0;
			tmr_reg <= '0;
		end else begin
			flag_reg <= new_fault || (flag_reg && !clr_ok);
			done_reg <= (done_reg || expire) && !clr_ok;
			conf_reg <= expire;
			if (!flag_reg || clr_ok || done_reg) tmr_reg <= '0;
			else if (em.mon_en) tmr_reg <= tmr_reg + CNT_W'(1);
		end
	end

	assign em.flag = flag_reg;
	assign em.fault_level = fault_lvl;
	assign em.pin_sense = s2_reg;
	assign em.confirmed = conf_reg;

	clr_blocked_a: assert property (@(posedge clk) disable iff (srst)
		flag_reg && fault_lvl |=> flag_reg)
		else $error("flag cleared while input at fault level");
	timer_stop_a: assert property (@(posedge clk) disable iff (srst)
		flag_reg && clr_ok && !new_fault |=> !flag_reg && tmr_reg == '0
		##1 !conf_reg)
		else $error("timer kept running after flag clear");
	conf_cause_a: assert property (@(posedge clk) disable iff (srst)
		conf_reg |-> $past(flag_reg) && $past(tmr_reg) == $past(limit))
		else $error("fault confirmed without expired timer");
endmodule

// [rtl/ssoc_top.sv]
// Safe-state output control with external error monitoring
`timescale 1ns/100ps
`include "ssoc_map.svh"
module ssoc_top #(
	parameter int unsigned ANALOG_SELFTEST_W = 8,
	parameter bit HAS_LBIST = 1'b1,
	parameter bit HAS_HANDSHAKE = 1'b1,
	parameter int unsigned CNT_W = 20,
	parameter int unsigned T1_CYC =
		ssoc_pkg::ms_to_cyc(`SSOC_T1_MS, `SSOC_CLK_HZ),
	parameter int unsigned T2_CYC =
		ssoc_pkg::ms_to_cyc(`SSOC_T2_MS, `SSOC_CLK_HZ),
	parameter int unsigned T3_CYC =
		ssoc_pkg::ms_to_cyc(`SSOC_T3_MS, `SSOC_CLK_HZ),
	parameter int unsigned T4_CYC =
		ssoc_pkg::ms_to_cyc(`SSOC_T4_MS, `SSOC_CLK_HZ)
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire ssoc_pkg::ssoc_pwr_e PWR_STATE,
	input wire logic PWRUP_DONE,
	input wire logic SYS_RESET_RELEASED,
	input wire logic [ANALOG_SELFTEST_W-1:0] ANALOG_SELFTEST_FLAGS,
	input wire logic [1:0] LOGIC_SELFTEST_RESULT,
	input wire logic [3:0] FAULT_COUNT,
	input wire logic [`SSOC_FL_W-1:0] STICKY_FLAGS,
	input wire logic [`SSOC_LF_W-1:0] LIVE_FAULTS,
	input wire logic POWER_GOOD_SHORT,
	input wire logic EXT_FAIL_IN_N,
	input wire logic CMD_WR,
	input wire logic [7:0] CMD_DATA,
	input wire logic CFG_WR,
	input wire logic [1:0] CFG_TIMER_SEL,
	input wire logic CFG_RESET_EN,
	input wire logic EXT_ERROR_POLARITY,
	input wire logic EXT_FLAG_CLR,
	input wire logic EXT_ERR_MASK,
	input wire logic SAFE_FLT_CLR,
	input wire logic SAFE_FLT_MASK,
	input wire logic EXT_ERROR_PIN,
	input wire logic SAFE_STATE_I,
	output logic SAFE_STATE_O,
	output logic SAFE_STATE_OE,
	input wire logic WD_ENABLE,
	input wire logic GOOD_SERVICE,
	input wire logic BAD_SERVICE,
	input wire logic [2:0] CLEAR_RATIO,
	output logic SAFE_RELEASED,
	output logic SAFE_PIN_SENSE,
	output logic SAFE_PIN_SHORT_HIGH,
	output logic SAFE_PIN_SHORT_LOW,
	output logic SAFE_PIN_FAULT_IRQ,
	output logic EXT_ERROR_FLAG,
	output logic EXT_ERROR_PIN_SENSE,
	output logic [1:0] EXT_TIMER_SEL,
	output logic EXT_RESET_EN,
	output logic IRQ_OUT,
	output logic HARD_RESET_REQ,
	output logic [2:0] GOOD_SERVICE_COUNT,
	output logic COUNT_DEC
);
	localparam int unsigned DG_CYC =
		ssoc_pkg::us_to_cyc(`SSOC_DEGLITCH_US, `SSOC_CLK_HZ);

	ssoc_pkg::ssoc_safe_e state_reg, state_next;
	logic pin_s1_reg, pin_s2_reg, fail_s1_reg, fail_s2_reg;
	logic drv_d1_reg, drv_d2_reg;
	logic short_hi_reg, short_lo_reg, flt_irq_reg;
	logic [1:0] tsel_reg;
	logic rst_en_reg, hard_rst_reg;
	logic [2:0] good_cnt_reg, good_cnt_next;
	logic dec_reg;
	logic in_run, sys_on, release_ok, release_req, force_req, trip;
	logic ext_block, pin_short, flags_bad, ratio_on, ratio_hit;
	logic [`SSOC_FL_W-1:0] flag_care;

	ssoc_ext_error_monitor_if em();

	// Power state decode; standby, off and fail-safe all count as not run
	assign in_run = PWR_STATE == ssoc_pkg::PWR_RUN;
	assign sys_on = PWRUP_DONE && SYS_RESET_RELEASED;

	// External error monitor hookup, live only in run and monitored standby
	assign em.mon_en = sys_on && (in_run ||
		PWR_STATE == ssoc_pkg::PWR_MON_STBY);
	assign em.polarity = EXT_ERROR_POLARITY;
	assign em.timer_sel = tsel_reg;
	assign em.flag_clr = EXT_FLAG_CLR;

	ssoc_ext_error_monitor #(
		.CNT_W(CNT_W),
		.T1_CYC(T1_CYC),
		.T2_CYC(T2_CYC),
		.T3_CYC(T3_CYC),
		.T4_CYC(T4_CYC),
		.DG_CYC(DG_CYC)
	) u_ext_error_monitor (
		.clk(CLK),
		.srst(SRST),
		.ext_pin(EXT_ERROR_PIN),
		.em(em)
	);

	// Handshake flag is dropped from the check on parts without it
	assign flag_care = HAS_HANDSHAKE ? {`SSOC_FL_W{1'b1}} :
		~(`SSOC_FL_W'(1) << `SSOC_FL_HANDSHAKE);
	assign flags_bad = |(STICKY_FLAGS & flag_care);
	assign pin_short = short_hi_reg || short_lo_reg || POWER_GOOD_SHORT;
	// A pending or still-present external error blocks release
	assign ext_block = em.flag || em.fault_level;

	// Full release condition set, sampled when the request lands
	assign release_ok = in_run && sys_on
		&& ANALOG_SELFTEST_FLAGS == '0
		&& (!HAS_LBIST || LOGIC_SELFTEST_RESULT == `SSOC_LBIST_PASS)
		&& FAULT_COUNT == `SSOC_FAULT_COUNT_ZERO
		&& !flags_bad && !pin_short && !ext_block
		&& LIVE_FAULTS == '0 && fail_s2_reg;

	// Command decode; any code other than the two is ignored
	assign release_req = CMD_WR && CMD_DATA == `SSOC_CMD_RELEASE;
	assign force_req = CMD_WR && CMD_DATA == `SSOC_CMD_FORCE;

	// Anything that pulls a released pin back to the safe level
	assign trip = force_req || !in_run || !SYS_RESET_RELEASED
		|| (|LIVE_FAULTS) || !fail_s2_reg
		|| STICKY_FLAGS[`SSOC_FL_BANDGAP] || STICKY_FLAGS[`SSOC_FL_CLOCK]
		|| pin_short || em.confirmed;

	// Safe-state machine; a refused request leaves no trace behind
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ssoc_pkg::SS_HELD: begin
				if (release_req && release_ok) begin
					state_next = ssoc_pkg::SS_RELEASED;
				end
			end
			ssoc_pkg::SS_RELEASED: begin
				if (trip) begin
					state_next = ssoc_pkg::SS_HELD;
				end
			end
			default: begin
				state_next = ssoc_pkg::SS_HELD;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) state_reg <= ssoc_pkg::SS_HELD;
		else state_reg <= state_next;
	end

	// Open-drain pin: enable pulls low, release lets it float high
	assign SAFE_STATE_O = 1'b0;
	assign SAFE_STATE_OE = state_reg == ssoc_pkg::SS_HELD;
	assign SAFE_RELEASED = state_reg == ssoc_pkg::SS_RELEASED;

	// Pin synchronisers; drive is delayed to line up with sensed level
	always_ff @(posedge CLK) begin
		pin_s1_reg <= SAFE_STATE_I;
		pin_s2_reg <= pin_s1_reg;
		fail_s1_reg <= EXT_FAIL_IN_N;
		fail_s2_reg <= fail_s1_reg;
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			drv_d1_reg <= 1'b1;
			drv_d2_reg <= 1'b1;
		end else begin
			drv_d1_reg <= SAFE_STATE_OE;
			drv_d2_reg <= drv_d1_reg;
		end
	end

	assign SAFE_PIN_SENSE = pin_s2_reg;

	// Short sense bits follow the mismatch live, no memory
	always_ff @(posedge CLK) begin
		if (SRST) begin
			short_hi_reg <= 1'b0;
			short_lo_reg <= 1'b0;
		end else begin
			short_hi_reg <= drv_d2_reg && pin_s2_reg;
			short_lo_reg <= !drv_d2_reg && !pin_s2_reg;
		end
	end

	assign SAFE_PIN_SHORT_HIGH = short_hi_reg;
	assign SAFE_PIN_SHORT_LOW = short_lo_reg;

	// Sticky short flag: a new short wins over a same-cycle clear
	always_ff @(posedge CLK) begin
		if (SRST) flt_irq_reg <= 1'b0;
		else flt_irq_reg <= short_hi_reg || short_lo_reg
			|| (flt_irq_reg && !SAFE_FLT_CLR);
	end

	assign SAFE_PIN_FAULT_IRQ = flt_irq_reg;
	assign IRQ_OUT = (flt_irq_reg && !SAFE_FLT_MASK)
		|| (em.flag && !EXT_ERR_MASK);

	// Monitor settings; writable only once the system is on
	always_ff @(posedge CLK) begin
		if (SRST) begin
			tsel_reg <= `SSOC_TSEL_RESET;
			rst_en_reg <= `SSOC_RESET_EN_RESET;
		end else if (CFG_WR && sys_on) begin
			tsel_reg <= CFG_TIMER_SEL;
			rst_en_reg <= CFG_RESET_EN;
		end
	end

	assign EXT_TIMER_SEL = tsel_reg;
	assign EXT_RESET_EN = rst_en_reg;
	assign EXT_ERROR_FLAG = em.flag;
	assign EXT_ERROR_PIN_SENSE = em.pin_sense;

	// Hard reset only when the pin had been released beforehand
	always_ff @(posedge CLK) begin
		if (SRST) hard_rst_reg <= 1'b0;
		else hard_rst_reg <= em.confirmed && rst_en_reg
			&& state_reg == ssoc_pkg::SS_RELEASED;
	end

	assign HARD_RESET_REQ = hard_rst_reg;

	// Good-service run counter; bad service restarts the run
	assign ratio_on = WD_ENABLE && CLEAR_RATIO != `SSOC_RATIO_OFF;
	assign ratio_hit = ratio_on && GOOD_SERVICE
		&& (good_cnt_reg + 3'h1) == CLEAR_RATIO;

	always_comb begin
		good_cnt_next = good_cnt_reg;
		if (BAD_SERVICE) good_cnt_next = 3'h0;
		else if (ratio_hit) good_cnt_next = 3'h0;
		else if (GOOD_SERVICE && good_cnt_reg != 3'h7) begin
			good_cnt_next = good_cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			good_cnt_reg <= 3'h0;
			dec_reg <= 1'b0;
		end else begin
			good_cnt_reg <= good_cnt_next;
			dec_reg <= ratio_hit && !BAD_SERVICE;
		end
	end

	assign GOOD_SERVICE_COUNT = good_cnt_reg;
	assign COUNT_DEC = dec_reg;

	// Checks on the safe-state sequence, short sense, interrupts, hard reset and counter
	sequence s_release_cmd;
		release_req && release_ok;
	endsequence

	sequence s_held_low;
		SAFE_STATE_OE [*3];
	endsequence

	// Released long enough for the delayed drive to show it
	sequence s_released;
		SAFE_RELEASED [*3];
	endsequence

	hold_not_run_a: assert property (@(posedge CLK) disable iff (SRST)
		!in_run |=> SAFE_STATE_OE)
		else $error("pin released outside run");
	release_cause_a: assert property (@(posedge CLK) disable iff (SRST)
		$rose(SAFE_RELEASED) |-> $past(CMD_WR)
		&& $past(CMD_DATA) == `SSOC_CMD_RELEASE)
		else $error("release without release code");
	release_cond_a: assert property (@(posedge CLK) disable iff (SRST)
		$rose(SAFE_RELEASED) |-> $past(release_ok) && $past(!ext_block))
		else $error("release with a condition unmet");
	release_grant_a: assert property (@(posedge CLK) disable iff (SRST)
		(SAFE_STATE_OE and s_release_cmd) |=> SAFE_RELEASED)
		else $error("valid release request not granted");
	force_low_a: assert property (@(posedge CLK) disable iff (SRST)
		SAFE_RELEASED && force_req |=> SAFE_STATE_OE [*2])
		else $error("force code did not pull pin low");
	trip_low_a: assert property (@(posedge CLK) disable iff (SRST)
		SAFE_RELEASED && (|LIVE_FAULTS || !SYS_RESET_RELEASED)
		|=> SAFE_STATE_OE)
		else $error("live fault did not pull pin low");
	confirm_low_a: assert property (@(posedge CLK) disable iff (SRST)
		em.confirmed |=> SAFE_STATE_OE)
		else $error("confirmed external fault left pin high");
	short_high_a: assert property (@(posedge CLK) disable iff (SRST)
		s_held_low ##0 pin_s2_reg |=> SAFE_PIN_SHORT_HIGH)
		else $error("short to high not reported");
	irq_sticky_a: assert property (@(posedge CLK) disable iff (SRST)
		SAFE_PIN_FAULT_IRQ && !SAFE_FLT_CLR |=> SAFE_PIN_FAULT_IRQ)
		else $error("short flag lost without clear");
	irq_out_a: assert property (@(posedge CLK) disable iff (SRST)
		SAFE_PIN_SHORT_LOW && !SAFE_FLT_MASK |=> IRQ_OUT)
		else $error("unmasked short did not raise interrupt");
	hard_reset_a: assert property (@(posedge CLK) disable iff (SRST)
		HARD_RESET_REQ |-> $past(SAFE_RELEASED) && $past(rst_en_reg))
		else $error("hard reset without prior release");
	count_dec_a: assert property (@(posedge CLK) disable iff (SRST)
		COUNT_DEC |-> $past(WD_ENABLE) && $past(good_cnt_reg) + 3'h1
		== $past(CLEAR_RATIO) && GOOD_SERVICE_COUNT == 3'h0)
		else $error("decrement without full good run");

	// Short, monitor and counter checks
	short_low_a: assert property (@(posedge CLK) disable iff (SRST)
		s_released ##0 !pin_s2_reg |=> SAFE_PIN_SHORT_LOW)
		else $error("short to low not reported");
	flt_set_a: assert property (@(posedge CLK) disable iff (SRST)
		SAFE_PIN_SHORT_HIGH |=> SAFE_PIN_FAULT_IRQ)
		else $error("short did not set the fault flag");
	mon_off_a: assert property (@(posedge CLK) disable iff (SRST)
		!em.mon_en && !em.flag |=> !em.flag)
		else $error("error flag set while monitoring off");
	ratio_off_a: assert property (@(posedge CLK) disable iff (SRST)
		!ratio_on |=> !COUNT_DEC)
		else $error("decrement while good-service clear is off");
endmodule

// [dv/ssoc_pin_model.sv]
// Partner model of the safe-state wire: pull-up plus short injection
`timescale 1ns/100ps
module ssoc_pin_model (
	input wire logic drive_low,
	input wire logic drive_val,
	input wire logic [1:0] short_mode,
	output logic pin
);
	// A short beats any driver; a released wire rises on the pull-up
	always_comb begin
		if (short_mode == 2'h1)
			pin = 1'b1;
		else if (short_mode == 2'h2)
			pin = 1'b0;
		else if (drive_low)
			pin = drive_val;
		else
			pin = 1'b1;
	end
endmodule

// [dv/ssoc_top_tb.sv]
// Self-checking bench for the safe-state output control block
`timescale 1ns/100ps
module ssoc_top_tb;
	logic clk = 1'b0, srst = 1'b1, pwrup = 1'b1, rrel = 1'b1, pgs = 1'b0;
	logic exfn = 1'b1, cwr = 1'b0, fwr = 1'b0, rsten = 1'b0, pol = 1'b0;
	logic eclr = 1'b0, emsk = 1'b0, fclr = 1'b0, fmsk = 1'b0, epin = 1'b0;
	logic wden = 1'b1, good = 1'b0, bad = 1'b0;
	logic [7:0] code = 8'h00, analog_selftest = 8'h00;
	logic [1:0] lbist = 2'h3, tsel = 2'h3, shm = 2'h0, tsel_o;
	logic [3:0] fcnt = 4'h0;
	logic [2:0] ratio = 3'h0, gcnt;
	logic [10:0] sticky = 11'h000;
	logic [6:0] live = 7'h00;
	ssoc_pkg::ssoc_pwr_e pwr = ssoc_pkg::PWR_RUN;
	logic pin, oe, so, rel, sns, s2h, s2l, firq, eflg, esns, irq, hrr, dec;
	logic rsten_o;
	logic [31:0] rng = 32'h4;
	int bad_count = 0, n_tests = 0, cyc = 0, m_rel = 0, m_ef = 0;
	int hr_n = 0, dec_n = 0, sl_n = 0, exp_dec = 0, gsc = 0;

	// Short timer limits keep the run brief; deglitch stays 100 cycles
	ssoc_top #(.T1_CYC(40), .T2_CYC(80), .T3_CYC(120), .T4_CYC(160)) u_dut (
		.CLK(clk), .SRST(srst), .PWR_STATE(pwr), .PWRUP_DONE(pwrup),
		.SYS_RESET_RELEASED(rrel), .ANALOG_SELFTEST_FLAGS(analog_selftest),
		.LOGIC_SELFTEST_RESULT(lbist), .FAULT_COUNT(fcnt),
		.STICKY_FLAGS(sticky), .LIVE_FAULTS(live), .POWER_GOOD_SHORT(pgs),
		.EXT_FAIL_IN_N(exfn), .CMD_WR(cwr), .CMD_DATA(code), .CFG_WR(fwr),
		.CFG_TIMER_SEL(tsel), .CFG_RESET_EN(rsten),
		.EXT_ERROR_POLARITY(pol), .EXT_FLAG_CLR(eclr), .EXT_ERR_MASK(emsk),
		.SAFE_FLT_CLR(fclr), .SAFE_FLT_MASK(fmsk), .EXT_ERROR_PIN(epin),
		.SAFE_STATE_I(pin), .SAFE_STATE_O(so), .SAFE_STATE_OE(oe),
		.WD_ENABLE(wden), .GOOD_SERVICE(good), .BAD_SERVICE(bad),
		.CLEAR_RATIO(ratio), .SAFE_RELEASED(rel), .SAFE_PIN_SENSE(sns),
		.SAFE_PIN_SHORT_HIGH(s2h), .SAFE_PIN_SHORT_LOW(s2l),
		.SAFE_PIN_FAULT_IRQ(firq), .EXT_ERROR_FLAG(eflg),
		.EXT_ERROR_PIN_SENSE(esns), .EXT_TIMER_SEL(tsel_o),
		.EXT_RESET_EN(rsten_o), .IRQ_OUT(irq), .HARD_RESET_REQ(hrr),
		.GOOD_SERVICE_COUNT(gcnt), .COUNT_DEC(dec));

	ssoc_pin_model u_pin (.drive_low(oe), .drive_val(so),
		.short_mode(shm), .pin(pin));

	always #50 clk = ~clk;

	// hrr and dec pulse for one cycle and s2l is a level; all three are counted on every edge
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (hrr === 1'b1)
			hr_n <= hr_n + 1;
		if (dec === 1'b1)
			dec_n <= dec_n + 1;
		if (s2l === 1'b1)
			sl_n <= sl_n + 1;
		if (cyc == 6000) begin
			bad_count++;
			end_of_test();
		end
	end

	function automatic logic [7:0] nxt();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction

	// Conditions that pull a released pin low in the model
	function automatic bit trip();
		return !rrel || sticky[9:8] != 2'h0 || live != 7'h00 || pgs ||
			!exfn || pwr != ssoc_pkg::PWR_RUN || shm != 2'h0;
	endfunction

	function automatic bit ok();
		return pwrup && rrel && analog_selftest == 8'h00 && lbist == 2'h3 &&
			fcnt == 4'h0 && sticky == 11'h000 && !trip() && m_ef == 0 &&
			!epin;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Inputs always move 1 ns after the rising edge
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			if (trip())
				m_rel = 0;
		end
	endtask

	task automatic cmd(input logic [7:0] c);
		code = c;
		cwr = 1'b1;
		if (c == 8'hA5 && ok())
			m_rel = 1;
		if (c == 8'h4B)
			m_rel = 0;
		step(1);
		cwr = 1'b0;
		step(1);
	endtask

	task automatic cmp_rel();
		chk({7'h00, rel}, m_rel[7:0]);
		chk({7'h00, oe}, {7'h00, m_rel == 0});
	endtask

	task automatic blk(input int i, input logic on);
		case (i)
			0: pwrup = !on;
			1: rrel = !on;
			2: analog_selftest = on ? (nxt() | 8'h01) : 8'h00;
			3: lbist = on ? 2'h2 : 2'h3;
			4: fcnt = on ? 4'h1 : 4'h0;
			23: pgs = on;
			24: exfn = !on;
			default: begin
				if (i >= 25)
					pwr = on ? ssoc_pkg::ssoc_pwr_e'(3'((i - 22) % 6)) :
						ssoc_pkg::PWR_RUN;
				else if (i < 16)
					sticky[i - 5] = on;
				else
					live[i - 16] = on;
			end
		endcase
	endtask

	task automatic goods(input int n);
		repeat (n) begin
			good = 1'b1;
			if (wden && ratio != 3'h0) begin
				gsc++;
				if (gsc == ratio) begin
					exp_dec++;
					gsc = 0;
				end
			end
			step(1);
			good = 1'b0;
			step(1);
		end
	endtask

	task automatic pulse_bad();
		bad = 1'b1;
		gsc = 0;
		step(1);
		bad = 1'b0;
		step(1);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence; the filter needs about 103 cycles after reset
	initial begin
		logic [7:0] c;
		repeat (12) @(posedge clk);
		#1;
		srst = 1'b0;
		chk({oe, rel, tsel_o, rsten_o, firq, eflg, hrr}, 8'h90);
		chk({7'h00, so}, 8'h00);
		step(110);
		cmd(8'hA5);
		cmp_rel();
		// Sense lags the wire by two flops
		step(1);
		chk({7'h00, sns}, 8'h01);
		repeat (12) begin
			c = nxt();
			if (c == 8'h4B)
				c = 8'h00;
			cmd(c);
			cmp_rel();
		end
		cmd(8'h4B);
		cmp_rel();
		// Each condition refuses, is forgotten, and trips if it must
		for (int i = 0; i < 29; i++) begin
			blk(i, 1'b1);
			step(4);
			cmd(8'hA5);
			cmp_rel();
			blk(i, 1'b0);
			step(4);
			cmp_rel();
			cmd(8'hA5);
			cmp_rel();
			if (i == 1 || i == 13 || i == 14 || i >= 16) begin
				blk(i, 1'b1);
				step(4);
				cmp_rel();
				blk(i, 1'b0);
				step(4);
			end else begin
				cmd(8'h4B);
				cmp_rel();
			end
		end
		// Pin shorted low while released
		cmd(8'hA5);
		shm = 2'h2;
		step(8);
		chk({7'h00, sl_n != 0}, 8'h01);
		cmp_rel();
		chk({5'h00, s2l, firq, irq}, 8'h03);
		shm = 2'h0;
		fmsk = 1'b1;
		step(1);
		chk({7'h00, irq}, 8'h00);
		fclr = 1'b1;
		step(1);
		fclr = 1'b0;
		step(1);
		chk({7'h00, firq}, 8'h00);
		fmsk = 1'b0;
		// Pin shorted high while held low
		shm = 2'h1;
		step(5);
		chk({6'h00, s2h, sns}, 8'h03);
		cmd(8'hA5);
		cmp_rel();
		shm = 2'h0;
		step(5);
		chk({5'h00, s2h, sns, firq}, 8'h01);
		fclr = 1'b1;
		step(1);
		fclr = 1'b0;
		// External error cleared in time
		fwr = 1'b1;
		rsten = 1'b1;
		step(1);
		fwr = 1'b0;
		step(1);
		chk({5'h00, tsel_o, rsten_o}, 8'h07);
		cmd(8'hA5);
		epin = 1'b1;
		step(106);
		chk({6'h00, eflg, irq}, 8'h03);
		eclr = 1'b1;
		step(1);
		eclr = 1'b0;
		step(1);
		chk({6'h00, eflg, esns}, 8'h03);
		epin = 1'b0;
		step(117);
		eclr = 1'b1;
		step(1);
		eclr = 1'b0;
		step(100);
		chk({6'h00, eflg, hr_n != 0}, 8'h00);
		cmp_rel();
		// External error left standing until the timer confirms it
		epin = 1'b1;
		m_ef = 1;
		step(240);
		cmp_rel();
		step(40);
		m_rel = 0;
		cmp_rel();
		chk({7'h00, hr_n == 1}, 8'h01);
		epin = 1'b0;
		step(110);
		cmd(8'hA5);
		cmp_rel();
		eclr = 1'b1;
		m_ef = 0;
		step(1);
		eclr = 1'b0;
		step(2);
		cmd(8'hA5);
		cmp_rel();
		// Good-service ratios, a bad service and a disabled counter
		pulse_bad();
		ratio = 3'h3;
		goods(7);
		chk(8'(dec_n), 8'(exp_dec));
		chk({5'h00, gcnt}, 8'(gsc));
		pulse_bad();
		chk({5'h00, gcnt}, 8'h00);
		ratio = 3'h7;
		goods(7);
		ratio = 3'h0;
		goods(8);
		pulse_bad();
		ratio = 3'h1;
		wden = 1'b0;
		goods(3);
		chk(8'(dec_n), 8'(exp_dec));
		// Falling-edge polarity after a fresh reset
		srst = 1'b1;
		pol = 1'b1;
		epin = 1'b1;
		step(3);
		srst = 1'b0;
		m_rel = 0;
		step(110);
		chk({7'h00, eflg}, 8'h00);
		epin = 1'b0;
		step(106);
		chk({7'h00, eflg}, 8'h01);
		end_of_test();
	end
endmodule
